// [cgb_clock_gate_bank.sv]
// clock gate bank: apb register slave with enable, disable and status
`timescale 1ns/1ps
`include "cgb_defines.svh"

// Operation
// RULE_01: sys enable bit 7 starts usb clock
// RULE_02: sys enable bits 8-10 start prog outputs
// RULE_03: sys disable bit 0 stops processor clock
// RULE_04: sys disable bit 7 stops usb clock
// RULE_05: sys disable bits 8-10 stop prog outputs
// RULE_06: status bit 0 shows processor clock, reset 0x01
// RULE_07: status bit 7 shows usb clock
// RULE_08: status bits 8-10 show prog outputs
// RULE_09: periph enable bits 2-31 start peripheral clocks
// RULE_10: unimplemented peripheral bits have no effect
// RULE_11: periph status read-only at 0x18, resets zero
// RULE_12: sys registers at 0x00, 0x04, 0x08
// RULE_13: periph disable bits 2-31 stop clocks
// RULE_14: periph status shows each clock state
// RULE_15: state bits drive status and gates directly; here the gates are registered and follow the state one cycle later
module cgb_clock_gate_bank #(
	parameter logic [31:0] PID_IMPL = 32'hffff_fffc
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output cgb_pkg::cgb_gates_s o_gates
);

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (PID_IMPL[1:0] != 2'h0)
	begin : g_bad_impl
		$error("peripheral ids 0 and 1 cannot be implemented");
	end

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic known_addr(input logic [7:0] a);
		case (a)
			`CGB_OFF_SYS_EN, `CGB_OFF_SYS_DIS, `CGB_OFF_SYS_STATE,
			`CGB_OFF_PER_EN, `CGB_OFF_PER_DIS, `CGB_OFF_PER_STATE,
			`CGB_OFF_OSC_CFG, `CGB_OFF_FREQ_MEAS, `CGB_OFF_PLL_CFG,
			`CGB_OFF_MCK_CFG, `CGB_OFF_PROG_CLOCK_OUT_0_CFG, `CGB_OFF_PROG_CLOCK_OUT_1_CFG,
			`CGB_OFF_IRQ_EN, `CGB_OFF_IRQ_DIS, `CGB_OFF_READY,
			`CGB_OFF_IRQ_MASK: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	endfunction

	logic setup;
	logic wr;
	logic [31:0] wd;
	assign setup = i_psel && !i_penable;
	assign wr = i_psel && i_penable && i_pwrite && o_pready;
	assign wd = i_pwdata;

	function automatic logic wr_at(input logic w, input logic [7:0] a,
		input logic [7:0] off);
		wr_at = w && (a == off);
	endfunction

	// ------------------------------------------------------------
	// gate state bits
	// ------------------------------------------------------------
	logic proc_q;
	logic usb_q;
	logic [2:0] pck_q;
	logic [31:0] per_q;

	// RULE_03 processor stop
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			proc_q <= 1'b1;
		else if (wr_at(wr, i_paddr, `CGB_OFF_SYS_DIS) && wd[`CGB_BIT_PROC])
			proc_q <= 1'b0;
	end

	// RULE_01 RULE_04 usb set clear
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			usb_q <= 1'b0;
		else if (wr_at(wr, i_paddr, `CGB_OFF_SYS_EN) && wd[`CGB_BIT_USB])
			usb_q <= 1'b1;
		else if (wr_at(wr, i_paddr, `CGB_OFF_SYS_DIS) && wd[`CGB_BIT_USB])
			usb_q <= 1'b0;
	end

	// RULE_02 RULE_05 prog outputs
	for (genvar k = 0; k < `CGB_NUM_PCK; k++)
	begin : g_pck
		always_ff @(posedge i_clk_sys or negedge i_rst_n)
		begin
			if (!i_rst_n)
				pck_q[k] <= 1'b0;
			else if (wr_at(wr, i_paddr, `CGB_OFF_SYS_EN)
				&& wd[`CGB_BIT_PCK_LO + k])
				pck_q[k] <= 1'b1;
			else if (wr_at(wr, i_paddr, `CGB_OFF_SYS_DIS)
				&& wd[`CGB_BIT_PCK_LO + k])
				pck_q[k] <= 1'b0;
		end
	end

	// RULE_09 RULE_10 RULE_13 peripheral set clear
	for (genvar p = 0; p < 32; p++)
	begin : g_per
		if (p >= `CGB_BIT_PID_LO && PID_IMPL[p])
		begin : g_impl
			always_ff @(posedge i_clk_sys or negedge i_rst_n)
			begin
				if (!i_rst_n)
					per_q[p] <= 1'b0;
				else if (wr_at(wr, i_paddr, `CGB_OFF_PER_EN) && wd[p])
					per_q[p] <= 1'b1;
				else if (wr_at(wr, i_paddr, `CGB_OFF_PER_DIS) && wd[p])
					per_q[p] <= 1'b0;
			end
		end
		else
		begin : g_none
			assign per_q[p] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// other controller registers, stored only
	// ------------------------------------------------------------
	logic [31:0] osc_q;
	logic [31:0] pll_q;
	logic [31:0] mck_q;
	logic [31:0] prog_clock_out_0_q;
	logic [31:0] prog_clock_out_1_q;
	logic [31:0] imask_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			osc_q <= `CGB_RST_OSC_CFG;
			pll_q <= `CGB_RST_PLL_CFG;
			mck_q <= `CGB_RST_MCK_CFG;
			prog_clock_out_0_q <= `CGB_RST_PCK_CFG;
			prog_clock_out_1_q <= `CGB_RST_PCK_CFG;
		end
		else
		begin
			if (wr_at(wr, i_paddr, `CGB_OFF_OSC_CFG))
				osc_q <= wd;
			if (wr_at(wr, i_paddr, `CGB_OFF_PLL_CFG))
				pll_q <= wd;
			if (wr_at(wr, i_paddr, `CGB_OFF_MCK_CFG))
				mck_q <= wd;
			if (wr_at(wr, i_paddr, `CGB_OFF_PROG_CLOCK_OUT_0_CFG))
				prog_clock_out_0_q <= wd;
			if (wr_at(wr, i_paddr, `CGB_OFF_PROG_CLOCK_OUT_1_CFG))
				prog_clock_out_1_q <= wd;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			imask_q <= `CGB_RST_IRQ_MASK;
		else if (wr_at(wr, i_paddr, `CGB_OFF_IRQ_EN))
			imask_q <= imask_q | wd;
		else if (wr_at(wr, i_paddr, `CGB_OFF_IRQ_DIS))
			imask_q <= imask_q & ~wd;
	end

	// ------------------------------------------------------------
	// status words
	// ------------------------------------------------------------
	logic [31:0] sys_state;
	// RULE_06 RULE_07 RULE_08 status build
	always_comb
	begin
		sys_state = 32'h0000_0000;
		sys_state[`CGB_BIT_PROC] = proc_q;
		sys_state[`CGB_BIT_USB] = usb_q;
		sys_state[`CGB_BIT_PCK_LO +: `CGB_NUM_PCK] = pck_q;
	end

	logic [31:0] rd_d;
	// RULE_11 RULE_12 RULE_14 read mux
	always_comb
	begin
		case (i_paddr)
			`CGB_OFF_SYS_STATE: rd_d = sys_state;
			`CGB_OFF_PER_STATE: rd_d = per_q;
			`CGB_OFF_OSC_CFG: rd_d = osc_q;
			`CGB_OFF_FREQ_MEAS: rd_d = `CGB_RST_FREQ_MEAS;
			`CGB_OFF_PLL_CFG: rd_d = pll_q;
			`CGB_OFF_MCK_CFG: rd_d = mck_q;
			`CGB_OFF_PROG_CLOCK_OUT_0_CFG: rd_d = prog_clock_out_0_q;
			`CGB_OFF_PROG_CLOCK_OUT_1_CFG: rd_d = prog_clock_out_1_q;
			`CGB_OFF_READY: rd_d = `CGB_RST_READY;
			`CGB_OFF_IRQ_MASK: rd_d = imask_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// apb answer: ready one cycle after setup
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end
		else
		begin
			o_pready <= setup;
			o_pslverr <= setup && !known_addr(i_paddr);
			o_prdata <= (setup && !i_pwrite) ? rd_d : 32'h0000_0000;
		end
	end

	// RULE_15 gate outputs from state
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_gates <= '{proc: 1'b1, usb: 1'b0, processor_clock_bit: 3'h0, periph: 32'h0};
		else
			o_gates <= '{proc: proc_q, usb: usb_q, processor_clock_bit: pck_q,
				periph: per_q};
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_sys_en_usb;
		wr && i_paddr == `CGB_OFF_SYS_EN && wd[`CGB_BIT_USB];
	endsequence

	usb_enable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_01
		s_sys_en_usb |=> usb_q) else $error("usb clock not enabled");
	pck_enable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_02
		wr && i_paddr == `CGB_OFF_SYS_EN |=> (pck_q & $past(wd[10:8])) == $past(wd[10:8]))
		else $error("prog output not enabled");
	proc_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_03
		wr && i_paddr == `CGB_OFF_SYS_DIS && wd[0] |=> !proc_q ##1 !o_gates.proc)
		else $error("processor clock not stopped");
	usb_disable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_04
		wr && i_paddr == `CGB_OFF_SYS_DIS && wd[7] && !(wr && i_paddr == `CGB_OFF_SYS_EN) |=> !usb_q)
		else $error("usb clock not disabled");
	pck_disable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_05
		wr && i_paddr == `CGB_OFF_SYS_DIS |=> (pck_q & $past(wd[10:8])) == 3'h0)
		else $error("prog output not disabled");
	sys_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_06
		setup && !i_pwrite && i_paddr == `CGB_OFF_SYS_STATE |=> o_prdata == $past(sys_state) && o_pready)
		else $error("system status read wrong");
	per_enable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_09
		wr && i_paddr == `CGB_OFF_PER_EN |=> (per_q & $past(wd) & PID_IMPL) == ($past(wd) & PID_IMPL))
		else $error("peripheral clock not enabled");
	per_unused_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_10
		(per_q & ~PID_IMPL) == 32'h0) else $error("unused peripheral bit set");
	per_disable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_13
		wr && i_paddr == `CGB_OFF_PER_DIS |=> (per_q & $past(wd)) == 32'h0)
		else $error("peripheral clock not disabled");
	gate_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_15
		##1 o_gates.periph == $past(per_q) && o_gates.usb == $past(usb_q))
		else $error("gate output does not follow state");

	// ------------------------------------------------------------
	// bus answer and hold checks
	// ------------------------------------------------------------
	logic sys_touch;
	logic per_touch;
	assign sys_touch = wr && (i_paddr == `CGB_OFF_SYS_EN
		|| i_paddr == `CGB_OFF_SYS_DIS);
	assign per_touch = wr && (i_paddr == `CGB_OFF_PER_EN
		|| i_paddr == `CGB_OFF_PER_DIS);

	sequence s_setup;
		i_psel && !i_penable;
	endsequence

	sequence s_wo_read;
		s_setup ##0 (!i_pwrite && (i_paddr == `CGB_OFF_SYS_EN
			|| i_paddr == `CGB_OFF_SYS_DIS || i_paddr == `CGB_OFF_PER_EN
			|| i_paddr == `CGB_OFF_PER_DIS));
	endsequence

	sequence s_per_read;
		s_setup ##0 (!i_pwrite && i_paddr == `CGB_OFF_PER_STATE);
	endsequence

	// RULE_12 ready after setup
	ready_pulse_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n) s_setup |=> o_pready)
		else $error("ready missing after setup");

	// RULE_12 ready one cycle
	ready_once_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n) o_pready |=> !o_pready)
		else $error("ready stands too long");

	// RULE_12 unmapped gives error
	err_unmapped_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n) s_setup ##0 !known_addr(i_paddr) |=> o_pslverr)
		else $error("unmapped address without error");

	// RULE_12 mapped no error
	err_mapped_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n) s_setup ##0 known_addr(i_paddr) |=> !o_pslverr)
		else $error("mapped address gave error");

	// RULE_12 idle data zero
	read_idle_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n) !o_pready |-> o_prdata == 32'h0000_0000)
		else $error("read data outside answer");

	// RULE_12 write-only reads zero
	wo_read_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n) s_wo_read |=> o_prdata == 32'h0000_0000)
		else $error("write-only register read nonzero");

	// RULE_14 peripheral status read
	per_read_a: assert property (@(posedge i_clk_sys) // RULE_14
		disable iff (!i_rst_n) s_per_read |=> o_prdata == $past(per_q))
		else $error("peripheral status read wrong");

	// RULE_11 peripheral status read-only
	per_ro_a: assert property (@(posedge i_clk_sys) // RULE_11
		disable iff (!i_rst_n)
		wr && i_paddr == `CGB_OFF_PER_STATE |=> per_q == $past(per_q))
		else $error("peripheral status was written");

	// RULE_12 system status read-only
	sys_ro_a: assert property (@(posedge i_clk_sys) // RULE_12
		disable iff (!i_rst_n)
		wr && i_paddr == `CGB_OFF_SYS_STATE |=> sys_state == $past(sys_state))
		else $error("system status was written");

	// RULE_07 usb state holds
	usb_hold_a: assert property (@(posedge i_clk_sys) // RULE_07
		disable iff (!i_rst_n) !sys_touch |=> usb_q == $past(usb_q))
		else $error("usb clock changed unasked");

	// RULE_03 processor state holds
	proc_hold_a: assert property (@(posedge i_clk_sys) // RULE_03
		disable iff (!i_rst_n)
		!(wr && i_paddr == `CGB_OFF_SYS_DIS) |=> proc_q == $past(proc_q))
		else $error("processor clock changed unasked");

	// RULE_08 prog outputs hold
	pck_hold_a: assert property (@(posedge i_clk_sys) // RULE_08
		disable iff (!i_rst_n) !sys_touch |=> pck_q == $past(pck_q))
		else $error("prog output changed unasked");

	// RULE_14 peripherals hold
	per_hold_a: assert property (@(posedge i_clk_sys) // RULE_14
		disable iff (!i_rst_n) !per_touch |=> per_q == $past(per_q))
		else $error("peripheral clock changed unasked");

	// RULE_01 zero bit keeps usb
	usb_keep_a: assert property (@(posedge i_clk_sys) // RULE_01
		disable iff (!i_rst_n) wr && i_paddr == `CGB_OFF_SYS_EN
		&& !wd[`CGB_BIT_USB] |=> usb_q == $past(usb_q))
		else $error("usb clock changed by zero bit");

	// RULE_02 enable never clears
	pck_keep_a: assert property (@(posedge i_clk_sys) // RULE_02
		disable iff (!i_rst_n) wr && i_paddr == `CGB_OFF_SYS_EN
		|=> (~pck_q & $past(pck_q)) == 3'h0)
		else $error("prog output cleared by enable");

	// RULE_15 remaining gates follow
	gate_rest_a: assert property (@(posedge i_clk_sys) // RULE_15
		disable iff (!i_rst_n) 1'b1 |=> o_gates.processor_clock_bit == $past(pck_q)
		&& o_gates.proc == $past(proc_q))
		else $error("gate output does not follow prog state");

	// RULE_06 system reset state
	state_reset_a: assert property (@(posedge i_clk_sys) // RULE_06
		disable iff (!i_rst_n) $rose(i_rst_n) |-> proc_q && !usb_q
		&& pck_q == 3'h0)
		else $error("system state wrong after reset");

	// RULE_11 peripheral reset state
	per_reset_a: assert property (@(posedge i_clk_sys) // RULE_11
		disable iff (!i_rst_n) $rose(i_rst_n) |-> per_q == 32'h0000_0000)
		else $error("peripheral state wrong after reset");
endmodule

// [cgb_defines.svh]
// register offsets, field positions and reset values of the clock gate bank
`ifndef CGB_DEFINES_SVH
`define CGB_DEFINES_SVH
`define CGB_OFF_SYS_EN 8'h00
`define CGB_OFF_SYS_DIS 8'h04
`define CGB_OFF_SYS_STATE 8'h08
`define CGB_OFF_PER_EN 8'h10
`define CGB_OFF_PER_DIS 8'h14
`define CGB_OFF_PER_STATE 8'h18
`define CGB_OFF_OSC_CFG 8'h20
`define CGB_OFF_FREQ_MEAS 8'h24
`define CGB_OFF_PLL_CFG 8'h2c
`define CGB_OFF_MCK_CFG 8'h30
`define CGB_OFF_PROG_CLOCK_OUT_0_CFG 8'h40
`define CGB_OFF_PROG_CLOCK_OUT_1_CFG 8'h44
`define CGB_OFF_IRQ_EN 8'h60
`define CGB_OFF_IRQ_DIS 8'h64
`define CGB_OFF_READY 8'h68
`define CGB_OFF_IRQ_MASK 8'h6c
`define CGB_BIT_PROC 0
`define CGB_BIT_USB 7
`define CGB_BIT_PCK_LO 8
`define CGB_NUM_PCK 3
`define CGB_BIT_PID_LO 2
`define CGB_RST_OSC_CFG 32'h0000_0000
`define CGB_RST_FREQ_MEAS 32'h0000_0000
`define CGB_RST_PLL_CFG 32'h0000_3f00
`define CGB_RST_MCK_CFG 32'h0000_0000
`define CGB_RST_PCK_CFG 32'h0000_0000
`define CGB_RST_READY 32'h0000_0008
`define CGB_RST_IRQ_MASK 32'h0000_0000
`endif

// [cgb_pkg.sv]
// types shared by the clock gate bank
package cgb_pkg;
	typedef struct packed
	{
		logic proc;
		logic usb;
		logic [2:0] processor_clock_bit;
		logic [31:0] periph;
	} cgb_gates_s;
endpackage

// [clock_gate_enable_bank_tb_top.sv]
// self-checking bench for the clock gate bank
`timescale 1ns/1ps
module clock_gate_enable_bank_tb_top;
	localparam logic [31:0] IMPL = 32'h0fff_fffc;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	cgb_pkg::cgb_gates_s o_gates;
	integer err_count = 0;
	integer checked = 0;
	integer seed = 32'h845283b6;
	integer i;
	logic [31:0] m_sys = 32'h0000_0001;
	logic [31:0] m_per = 32'h0000_0000;
	logic [31:0] rd;
	logic er;
	logic [7:0] wo_q[$] = '{8'h00, 8'h04, 8'h10, 8'h14};

	cgb_clock_gate_bank #(.PID_IMPL(IMPL)) dut (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_paddr(i_paddr),
		.i_pwdata(i_pwdata),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.o_gates(o_gates)
	);

	always #2 i_clk_sys = ~i_clk_sys;

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		integer n;
		n = 0;
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= ad;
		i_pwdata <= wd;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do
		begin
			@(posedge i_clk_sys);
			n = n + 1;
		end
		while (o_pready !== 1'b1 && n < 50);
		chk({31'h0, o_pready}, 32'h1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp,
		input logic experr);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, experr});
	endtask

	// write, then update the model of the gate state
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		apb(1'b1, ad, wd);
		chk({31'h0, er}, 32'h0);
		case (ad)
			8'h00: m_sys = m_sys | (wd & 32'h0000_0780);
			8'h04: m_sys = m_sys & ~(wd & 32'h0000_0781);
			8'h10: m_per = m_per | (wd & IMPL);
			8'h14: m_per = m_per & ~(wd & IMPL);
			default: m_sys = m_sys;
		endcase
	endtask

	// gates lag the state by one cycle
	task automatic gchk();
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({28'h0, o_gates.processor_clock_bit, o_gates.usb, o_gates.proc},
			{28'h0, m_sys[10:8], m_sys[7], m_sys[0]});
		chk(o_gates.periph, m_per);
	endtask

	task automatic step(input logic [7:0] ad, input logic [31:0] wd);
		wr(ad, wd);
		rdchk(8'h08, m_sys, 1'b0);
		rdchk(8'h18, m_per, 1'b0);
		gchk();
	endtask

	task automatic rstchk();
		rdchk(8'h08, 32'h0000_0001, 1'b0);
		rdchk(8'h18, 32'h0000_0000, 1'b0);
		rdchk(8'h2c, 32'h0000_3f00, 1'b0);
		rdchk(8'h68, 32'h0000_0008, 1'b0);
		gchk();
	endtask

	initial
	begin
		repeat (20000) @(posedge i_clk_sys);
		err_count = err_count + 1;
		print_verdict();
	end

	initial
	begin
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rstchk();
		$display("test reset done");
		foreach (wo_q[k])
			rdchk(wo_q[k], 32'h0, 1'b0);
		rdchk(8'h0c, 32'h0, 1'b1);
		apb(1'b1, 8'h08, 32'h0000_0000);
		apb(1'b1, 8'h18, 32'hffff_ffff);
		step(8'h00, 32'h0000_0000);
		$display("test map done");
		for (i = 0; i < 32; i = i + 1)
		begin
			step(8'h00, 32'h1 << i);
			step(8'h10, 32'h1 << i);
		end
		$display("test enable done");
		for (i = 31; i >= 0; i = i - 1)
		begin
			step(8'h04, 32'h1 << i);
			step(8'h14, 32'h1 << i);
		end
		$display("test disable done");
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		m_sys = 32'h0000_0001;
		m_per = 32'h0000_0000;
		rstchk();
		$display("test second reset done");
		for (i = 0; i < 60; i = i + 1)
			step(wo_q[$random(seed) & 3], $random(seed));
		$display("test random done");
		print_verdict();
	end
endmodule
